// ---- design/kms_pkg.sv ----
package kms_pkg;
  localparam int KMS_ROWS = 8;
  localparam int KMS_COLS = 20;
  localparam int KMS_KEYS = KMS_ROWS * KMS_COLS;
  localparam int KMS_DEPTH = 16;
  localparam int KMS_NMOD = 4;
  localparam int KMS_AW = 8;

  // Timing
  localparam int CLK_HZ = 50_000_000;
  localparam int CLK_MHZ = 50;
  localparam int TICK_HZ = 128_000;
  localparam logic [8:0] TICK_DIV = 9'(CLK_HZ / TICK_HZ);
  localparam int FILT_NS = 5000;
  localparam logic [8:0] FILT_CYC = 9'((FILT_NS * CLK_MHZ + 999) / 1000);

  // Register map
  localparam logic [KMS_AW-1:0] KMS_CTRL_OFF = 8'h00;
  localparam logic [KMS_AW-1:0] KMS_STAT_OFF = 8'h04;
  localparam logic [KMS_AW-1:0] KMS_DATA_OFF = 8'h08;
  localparam logic [KMS_AW-1:0] KMS_MODS_OFF = 8'h0c;
  localparam logic [KMS_AW-1:0] KMS_MHIT_OFF = 8'h10;

  // Field layout
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_COL_LSB = 8;
  localparam int CTRL_ROW_LSB = 16;
  localparam int STAT_GHOST_BIT = 0;
  localparam int STAT_OVF_BIT = 1;
  localparam int STAT_BUSY_BIT = 2;
  localparam int STAT_REQ_BIT = 3;
  localparam int STAT_CNT_LSB = 4;
  localparam int DATA_VALID_BIT = 8;

  // Reset values
  localparam logic [4:0] COL_LAST_RST = 5'h13;
  localparam logic [2:0] ROW_LAST_RST = 3'h7;
  localparam logic [31:0] MODS_RST = 32'hffff_ffff;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_SETTLE = 4'b0010,
    ST_SCAN = 4'b0100,
    ST_SEND = 4'b1000
  } kms_fsm_t;

  typedef struct packed {
    logic awvalid;
    logic [KMS_AW-1:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [KMS_AW-1:0] araddr;
    logic rready;
  } kms_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } kms_axi_rsp_t;
endpackage : kms_pkg

// ---- design/kms_scanner.sv ----
module kms_scanner import kms_pkg::*; (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic [KMS_ROWS-1:0] row_i,
  input wire logic osc_shared_i,
  input wire kms_axi_req_t axi_i,
  output logic [KMS_COLS-1:0] col_o,
  output logic clk_req_o,
  output kms_axi_rsp_t axi_o
);
  typedef struct packed {
    kms_fsm_t fsm;
    logic [8:0] div;
    logic tick;
    logic [7:0] rs1;
    logic [7:0] rs2;
    logic [7:0] rlast;
    logic [7:0] rows_f;
    logic [8:0] fcnt;
    logic en;
    logic [4:0] col_last;
    logic [2:0] row_last;
    logic [31:0] mods;
    logic [3:0] mod_live;
    logic [3:0] mod_hit;
    logic [2:0] row;
    logic [4:0] col;
    logic [7:0] kidx;
    logic [7:0] rowhit;
    logic any;
    logic ghost;
    logic ovf;
    logic [KMS_KEYS-1:0] map;
    logic [KMS_DEPTH-1:0][7:0] fifo;
    logic [3:0] wp;
    logic [3:0] rp;
    logic [4:0] cnt;
    logic [KMS_COLS-1:0] col_drv;
    logic req;
    logic aw_have;
    logic w_have;
    logic [KMS_AW-1:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    kms_axi_rsp_t rsp;
  } kms_st_t;

  kms_st_t s;
  kms_st_t n;
  logic [7:0] rows_m;
  logic key;
  logic is_mod;
  logic [1:0] mod_sel;
  logic last_row;
  logic last_col;
  logic push;
  logic pop;
  logic push_ok;
  logic [31:0] ctrl_rd;
  logic [31:0] stat_rd;
  logic [31:0] wr_val;

  function automatic logic [7:0] row_mask(input logic [2:0] last);
    logic [7:0] m;
    m = '0;
    for (int i = 0; i < KMS_ROWS; i++) begin
      m[i] = (3'(i) <= last);
    end
    return m;
  endfunction : row_mask

  function automatic logic [3:0] popc(input logic [7:0] v);
    logic [3:0] c;
    c = '0;
    for (int i = 0; i < KMS_ROWS; i++) begin
      c = c + 4'(v[i]);
    end
    return c;
  endfunction : popc

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] v, input logic [3:0] b);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (b[i]) begin
        r[i*8 +: 8] = v[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  function automatic logic [KMS_COLS-1:0] col_sel(input logic [4:0] c);
    return KMS_COLS'(1) << c;
  endfunction : col_sel

  always_comb begin
    n = s;
    n.tick = 1'b0;
    push = 1'b0;
    pop = 1'b0;
    push_ok = 1'b0;
    wr_val = '0;
    ctrl_rd = '0;
    ctrl_rd[CTRL_EN_BIT] = s.en;
    ctrl_rd[CTRL_COL_LSB +: 5] = s.col_last;
    ctrl_rd[CTRL_ROW_LSB +: 3] = s.row_last;
    stat_rd = '0;
    stat_rd[STAT_GHOST_BIT] = s.ghost;
    stat_rd[STAT_OVF_BIT] = s.ovf;
    stat_rd[STAT_BUSY_BIT] = (s.fsm != ST_IDLE);
    stat_rd[STAT_REQ_BIT] = s.req;
    stat_rd[STAT_CNT_LSB +: 5] = s.cnt;

    // Row pins: two-flop sync, then accept only a level stable for the filter time
    n.rs1 = row_i;
    n.rs2 = s.rs1;
    if (s.rs2 != s.rlast) begin
      n.rlast = s.rs2;
      n.fcnt = '0;
    end else if (s.fcnt != FILT_CYC) begin
      n.fcnt = s.fcnt + 9'h001;
    end else begin
      n.rows_f = s.rlast;
    end

    // Scan tick runs while the shared oscillator is on, ours or another's
    if (s.req || osc_shared_i) begin
      if (s.div == TICK_DIV - 9'h001) begin
        n.div = '0;
        n.tick = 1'b1;
      end else begin
        n.div = s.div + 9'h001;
      end
    end else begin
      n.div = '0;
    end

    rows_m = s.rows_f & row_mask(s.row_last);
    key = rows_m[s.row];
    last_row = (s.row == s.row_last);
    last_col = (s.col == s.col_last);
    is_mod = 1'b0;
    mod_sel = '0;
    for (int i = 0; i < KMS_NMOD; i++) begin
      if (s.mods[i*8 +: 8] == s.kidx) begin
        is_mod = 1'b1;
        mod_sel = 2'(i);
      end
    end

    // Register writes: both address and data held, then one response
    if (axi_i.awvalid && s.rsp.awready) begin
      n.aw_have = 1'b1;
      n.awaddr = axi_i.awaddr;
    end
    if (axi_i.wvalid && s.rsp.wready) begin
      n.w_have = 1'b1;
      n.wdata = axi_i.wdata;
      n.wstrb = axi_i.wstrb;
    end
    if (s.rsp.bvalid && axi_i.bready) begin
      n.rsp.bvalid = 1'b0;
    end
    if (s.aw_have && s.w_have && !s.rsp.bvalid) begin
      n.aw_have = 1'b0;
      n.w_have = 1'b0;
      n.rsp.bvalid = 1'b1;
      n.rsp.bresp = RESP_OKAY;
      unique case (s.awaddr)
        KMS_CTRL_OFF: begin
          wr_val = merge(ctrl_rd, s.wdata, s.wstrb);
          n.en = wr_val[CTRL_EN_BIT];
          // Column count above the matrix width saturates
          n.col_last = (wr_val[CTRL_COL_LSB +: 5] > COL_LAST_RST) ? COL_LAST_RST : wr_val[CTRL_COL_LSB +: 5];
          n.row_last = wr_val[CTRL_ROW_LSB +: 3];
        end
        KMS_STAT_OFF: begin
          if (s.wstrb[0]) begin
            n.ghost = s.ghost & ~s.wdata[STAT_GHOST_BIT];
            n.ovf = s.ovf & ~s.wdata[STAT_OVF_BIT];
          end
        end
        KMS_MODS_OFF: n.mods = merge(s.mods, s.wdata, s.wstrb);
        KMS_DATA_OFF, KMS_MHIT_OFF: ;
        default: n.rsp.bresp = RESP_SLVERR;
      endcase
    end
    n.rsp.awready = !n.aw_have && !n.rsp.bvalid;
    n.rsp.wready = !n.w_have && !n.rsp.bvalid;

    // Register reads
    if (s.rsp.rvalid && axi_i.rready) begin
      n.rsp.rvalid = 1'b0;
    end
    if (axi_i.arvalid && s.rsp.arready) begin
      n.rsp.rvalid = 1'b1;
      n.rsp.rresp = RESP_OKAY;
      n.rsp.rdata = '0;
      unique case (axi_i.araddr)
        KMS_CTRL_OFF: n.rsp.rdata = ctrl_rd;
        KMS_STAT_OFF: n.rsp.rdata = stat_rd;
        KMS_MODS_OFF: n.rsp.rdata = s.mods;
        KMS_MHIT_OFF: n.rsp.rdata[KMS_NMOD-1:0] = s.mod_hit;
        KMS_DATA_OFF: begin
          if (s.cnt != 5'h00) begin
            n.rsp.rdata[7:0] = s.fifo[s.rp];
            n.rsp.rdata[DATA_VALID_BIT] = 1'b1;
            pop = 1'b1;
          end
        end
        default: n.rsp.rresp = RESP_SLVERR;
      endcase
    end
    n.rsp.arready = !n.rsp.rvalid;

    unique case (s.fsm)
      ST_IDLE: begin
        n.col_drv = '1;
        n.req = 1'b0;
        n.rowhit = '0;
        n.kidx = '0;
        n.map = '0;
        n.row = '0;
        n.col = '0;
        n.any = 1'b0;
        n.mod_live = '0;
        n.mod_hit = '0;
        if (s.en && (|rows_m)) begin
          n.fsm = ST_SETTLE;
          n.req = 1'b1;
          n.col_drv = col_sel(5'h00);
        end
      end
      // One tick for the first column to settle through the filter
      ST_SETTLE: begin
        if (s.tick) begin
          n.fsm = ST_SCAN;
        end
      end
      ST_SCAN: begin
        if (s.tick) begin
          n.map[s.kidx] = 1'b0;
          if (key) begin
            n.any = 1'b1;
            if (s.rowhit[s.row]) begin
              // Possible ghost: hold the key back until the pattern clears
              n.ghost = 1'b1;
            end else if (is_mod) begin
              n.mod_live[mod_sel] = 1'b1;
              n.map[s.kidx] = 1'b1;
            end else begin
              n.map[s.kidx] = 1'b1;
              push = !s.map[s.kidx];
            end
          end
          if (last_row && (popc(rows_m) >= 4'h2)) begin
            n.rowhit = s.rowhit | rows_m;
          end
          if (last_row && last_col) begin
            n.fsm = ST_SEND;
          end else begin
            n.kidx = s.kidx + 8'h01;
            if (last_row) begin
              n.row = '0;
              n.col = s.col + 5'h01;
              n.col_drv = col_sel(s.col + 5'h01);
            end else begin
              n.row = s.row + 3'h1;
            end
          end
        end
      end
      ST_SEND: begin
        n.mod_hit = s.mod_live;
        n.mod_live = '0;
        n.row = '0;
        n.col = '0;
        n.kidx = '0;
        n.rowhit = '0;
        n.any = 1'b0;
        if (s.any) begin
          n.fsm = ST_SETTLE;
          n.col_drv = col_sel(5'h00);
        end else begin
          n.fsm = ST_IDLE;
          n.req = 1'b0;
          n.col_drv = '1;
        end
      end
      default: n.fsm = ST_IDLE;
    endcase

    if (!s.en) begin
      n.fsm = ST_IDLE;
      n.rowhit = '0;
      n.kidx = '0;
      n.req = 1'b0;
      n.col_drv = '1;
      push = 1'b0;
    end

    // Key-code buffer: a full buffer drops the newest code, never an old one
    if (pop) begin
      n.rp = s.rp + 4'h1;
    end
    if (push) begin
      if (s.cnt == 5'(KMS_DEPTH) && !pop) begin
        n.ovf = 1'b1;
      end else begin
        push_ok = 1'b1;
        n.fifo[s.wp] = s.kidx;
        n.wp = s.wp + 4'h1;
      end
    end
    n.cnt = s.cnt + 5'(push_ok) - 5'(pop);
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      s <= '0;
      s.fsm <= ST_IDLE;
      s.col_drv <= '1;
      s.col_last <= COL_LAST_RST;
      s.row_last <= ROW_LAST_RST;
      s.mods <= MODS_RST;
      s.rsp.awready <= 1'b1;
      s.rsp.wready <= 1'b1;
      s.rsp.arready <= 1'b1;
    end else begin
      s <= n;
    end
  end

  assign col_o = s.col_drv;
  assign clk_req_o = s.req;
  assign axi_o = s.rsp;

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);

  a_disabled_no_req: assert property (!s.en |=> !clk_req_o)
    else $error("clock request raised while disabled");
  a_idle_cols_high: assert property (s.fsm == ST_IDLE |-> col_o == '1 && s.rowhit == '0 && s.kidx == '0)
    else $error("idle state not clean");
  a_row_wraps: assert property (s.en && s.tick && s.fsm == ST_SCAN && last_row && !last_col
    |=> s.row == '0 && s.col == $past(s.col) + 5'h01 && col_o == col_sel(s.col))
    else $error("row counter did not wrap into next column");
  a_scan_ends: assert property (s.en && s.tick && s.fsm == ST_SCAN && last_row && last_col
    |=> s.fsm == ST_SEND)
    else $error("terminal counts did not end the pass");
  a_index_steps: assert property (s.en && s.tick && s.fsm == ST_SCAN && !(last_row && last_col)
    |=> s.kidx == $past(s.kidx) + 8'h01)
    else $error("key index did not advance");
  a_ghost_flags: assert property (s.tick && s.fsm == ST_SCAN && key && s.rowhit[s.row]
    |=> s.ghost && !$past(push))
    else $error("ghost not flagged or key not locked");
  a_end_to_idle: assert property (s.en && s.fsm == ST_SEND && !s.any
    |=> s.fsm == ST_IDLE && !clk_req_o && col_o == '1)
    else $error("empty pass did not return to idle");
  a_end_rescan: assert property (s.en && s.fsm == ST_SEND && s.any |=> s.fsm == ST_SETTLE && clk_req_o)
    else $error("pass with keys did not rescan");
  a_wake_on_row: assert property (s.en && s.fsm == ST_IDLE && (|rows_m) |=> clk_req_o ##[1:400] s.fsm == ST_SCAN)
    else $error("row activity did not start a scan");
  a_buffer_bound: assert property (s.cnt <= 5'(KMS_DEPTH) and (push && s.cnt == 5'(KMS_DEPTH) && !pop |=> s.ovf))
    else $error("buffer count or overflow wrong");
  a_pop_oldest: assert property (pop |=> axi_o.rdata[7:0] == $past(s.fifo[s.rp])
    && s.cnt == $past(s.cnt) + 5'($past(push_ok)) - 5'h01)
    else $error("read did not return the oldest entry");

  c_ghost: cover property (s.fsm == ST_SCAN ##1 s.ghost);
  c_overflow: cover property (push && s.cnt == 5'(KMS_DEPTH));
  c_rescan: cover property (s.fsm == ST_SEND && s.any);
  c_pop: cover property (pop);
endmodule : kms_scanner

// ---- verification/kms_matrix_model.sv ----
module kms_matrix_model import kms_pkg::*; (
  input wire logic [KMS_COLS-1:0] col_i,
  input wire logic [KMS_COLS*KMS_ROWS-1:0] key_i,
  output logic [KMS_ROWS-1:0] row_o
);
  // Key at column c, row r is bit c*8+r; open switches leave rows on pull-downs
  always_comb begin
    row_o = '0;
    for (int c = 0; c < KMS_COLS; c++) begin
      for (int r = 0; r < KMS_ROWS; r++) begin
        if (col_i[c] && key_i[c*KMS_ROWS+r]) row_o[r] = 1'b1;
      end
    end
  end
endmodule : kms_matrix_model

// ---- verification/tb_key_matrix_scanner.sv ----
module tb_key_matrix_scanner import kms_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk;
  logic rst;
  logic osc_shared;
  logic [KMS_ROWS-1:0] row;
  logic [KMS_COLS-1:0] col;
  logic clk_req;
  logic [KMS_COLS*KMS_ROWS-1:0] keys;
  kms_axi_req_t axi_req;
  kms_axi_rsp_t axi_rsp;
  logic [31:0] rd;
  logic [1:0] resp;
  int error_cnt;
  int total_checks;

  kms_matrix_model i_mat (.col_i(col), .key_i(keys), .row_o(row));
  kms_scanner i_dut (.ref_clk_i(clk), .sys_rst_i(rst), .row_i(row), .osc_shared_i(osc_shared),
    .axi_i(axi_req), .col_o(col), .clk_req_o(clk_req), .axi_o(axi_rsp));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    axi_req.awaddr <= a;
    axi_req.wdata <= d;
    axi_req.wstrb <= 4'hf;
    axi_req.awvalid <= 1'b1;
    axi_req.wvalid <= 1'b1;
    axi_req.bready <= 1'b1;
    do begin
      @(posedge clk);
      if (axi_req.awvalid && axi_rsp.awready) axi_req.awvalid <= 1'b0;
      if (axi_req.wvalid && axi_rsp.wready) axi_req.wvalid <= 1'b0;
    end while (axi_rsp.bvalid !== 1'b1);
    axi_req.bready <= 1'b0;
    resp = axi_rsp.bresp;
  endtask : bus_wr

  task automatic bus_rd(input logic [7:0] a);
    @(posedge clk);
    axi_req.araddr <= a;
    axi_req.arvalid <= 1'b1;
    axi_req.rready <= 1'b1;
    do begin
      @(posedge clk);
      if (axi_rsp.arready) axi_req.arvalid <= 1'b0;
    end while (axi_rsp.rvalid !== 1'b1);
    axi_req.rready <= 1'b0;
    rd = axi_rsp.rdata;
    resp = axi_rsp.rresp;
  endtask : bus_rd

  task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
    bus_rd(a);
    chk(name, exp, rd);
  endtask : rd_chk

  // Polling through status only; a data read would pop the buffer
  task automatic poll(input logic [31:0] m, input logic [31:0] v);
    int n;
    n = 0;
    do begin
      bus_rd(KMS_STAT_OFF);
      n++;
    end while ((rd & m) !== v && n < 3000);
    chk("status poll", v, rd & m);
  endtask : poll

  task automatic t_reset;
    chk("col_o", 32'h000f_ffff, 32'(col));
    chk("clk_req_o", 32'h0, 32'(clk_req));
    rd_chk("ctrl", KMS_CTRL_OFF, 32'h0007_1300);
    rd_chk("mods", KMS_MODS_OFF, 32'hffff_ffff);
    rd_chk("stat", KMS_STAT_OFF, 32'h0000_0000);
    rd_chk("data", KMS_DATA_OFF, 32'h0000_0000);
    rd_chk("unmapped", 8'h14, 32'h0000_0000);
    chk("unmapped rresp", 32'(RESP_SLVERR), 32'(resp));
    bus_wr(8'h14, 32'h0000_00ff);
    chk("unmapped bresp", 32'(RESP_SLVERR), 32'(resp));
    bus_wr(KMS_CTRL_OFF, 32'h0007_1f00);
    rd_chk("ctrl saturate", KMS_CTRL_OFF, 32'h0007_1300);
    $display("test reset done");
  endtask : t_reset

  // Another peripheral runs the oscillator, yet a disabled scanner stays quiet
  task automatic t_disabled;
    osc_shared <= 1'b1;
    keys <= 160'h1;
    repeat (1200) @(posedge clk);
    chk("clk_req_o off", 32'h0, 32'(clk_req));
    chk("col_o off", 32'h000f_ffff, 32'(col));
    rd_chk("stat off", KMS_STAT_OFF, 32'h0000_0000);
    keys <= '0;
    osc_shared <= 1'b0;
    // Let the row filter drain, else enabling starts a stray scan
    repeat (300) @(posedge clk);
    $display("test disabled done");
  endtask : t_disabled

  // Two rows in column 0 plus row 0 in column 1: the third key is a ghost
  task automatic t_ghost;
    bus_wr(KMS_CTRL_OFF, 32'h0001_0201);
    rd_chk("ctrl 3x2", KMS_CTRL_OFF, 32'h0001_0201);
    keys <= 160'h103;
    poll(32'h8, 32'h8);
    poll(32'h1, 32'h1);
    keys <= '0;
    poll(32'hc, 32'h0);
    chk("clk_req_o idle", 32'h0, 32'(clk_req));
    chk("col_o idle", 32'h000f_ffff, 32'(col));
    rd_chk("stat ghost", KMS_STAT_OFF, 32'h0000_0021);
    rd_chk("data first", KMS_DATA_OFF, 32'h0000_0100);
    rd_chk("data second", KMS_DATA_OFF, 32'h0000_0101);
    rd_chk("data empty", KMS_DATA_OFF, 32'h0000_0000);
    bus_wr(KMS_STAT_OFF, 32'h0000_0001);
    rd_chk("stat cleared", KMS_STAT_OFF, 32'h0000_0000);
    $display("test ghost done");
  endtask : t_ghost

  // Modifier at column 2 row 0 (index 4) plus plain key at column 0 row 1
  task automatic t_modifier;
    int t;
    bus_wr(KMS_MODS_OFF, 32'hffff_ff04);
    rd_chk("mods set", KMS_MODS_OFF, 32'hffff_ff04);
    keys <= 160'h1_0002;
    t = 0;
    do begin
      @(posedge clk);
      t++;
    end while (col !== 20'h0_0002 && t < 20000);
    t = 0;
    do begin
      @(posedge clk);
      t++;
    end while (col !== 20'h0_0004 && t < 2000);
    chk("column slot", 32'(2 * TICK_DIV), 32'(t));
    repeat (1000) @(posedge clk);
    rd_chk("mhit held", KMS_MHIT_OFF, 32'h0000_0001);
    keys <= '0;
    poll(32'hc, 32'h0);
    rd_chk("mhit released", KMS_MHIT_OFF, 32'h0000_0000);
    rd_chk("data plain key", KMS_DATA_OFF, 32'h0000_0101);
    rd_chk("data no modifier", KMS_DATA_OFF, 32'h0000_0000);
    bus_wr(KMS_MODS_OFF, 32'hffff_ffff);
    $display("test modifier done");
  endtask : t_modifier

  // One column of eight rows, pressed three times: third round overflows
  task automatic t_overflow;
    bus_wr(KMS_CTRL_OFF, 32'h0007_0001);
    for (int k = 1; k <= 3; k++) begin
      keys <= 160'hff;
      if (k < 3) poll(32'h1f0, 32'(k * 8) << 4);
      else poll(32'h2, 32'h2);
      keys <= '0;
      poll(32'hc, 32'h0);
    end
    rd_chk("stat full", KMS_STAT_OFF, 32'h0000_0102);
    for (int i = 0; i < 16; i++) begin
      rd_chk("data drain", KMS_DATA_OFF, 32'h100 | 32'(i % 8));
    end
    rd_chk("data empty", KMS_DATA_OFF, 32'h0000_0000);
    $display("test overflow done");
  endtask : t_overflow

  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : test_done

  initial begin
    rst = 1'b1;
    keys = '0;
    osc_shared = 1'b0;
    axi_req = '0;
    error_cnt = 0;
    total_checks = 0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_disabled();
    bus_wr(KMS_CTRL_OFF, 32'h0007_1301);
    t_ghost();
    t_modifier();
    t_overflow();
    test_done();
  end

  // Scans here need about a third of this span
  initial begin
    repeat (100000) @(posedge clk);
    error_cnt++;
    test_done();
  end
endmodule : tb_key_matrix_scanner
